// ==== hw/daofm_defs.svh ====
// constants for the dual converter output format and bus mux
// Contract
// - supply level: offset binary, stabilizer on
// - ground level: two's complement, stabilizer on
// - mid reference: two's complement, stabilizer off
// - floating: offset binary, stabilizer off
// - select low: two independent parallel buses
// - select high: both channels on first bus
// - indicator bit high for A, low B
// - each channel word is twelve bits
// - valid only with disable and sleep low
// - disable high floats outputs, conversion continues
// - sleep: outputs undefined, pipeline data lost
// - two's complement is offset binary, MSB inverted
`ifndef DAOFM_DEFS_SVH
`define DAOFM_DEFS_SVH

`define DAOFM_WORD_W 12
`define DAOFM_MSB 11
`define DAOFM_PAIR_W 24
`define DAOFM_BUF_DEPTH 2
`define DAOFM_MID_SCALE 12'h800
`define DAOFM_WORD_RST 12'h000
`define DAOFM_SEL_GROUND 2'h0
`define DAOFM_SEL_SUPPLY 2'h1
`define DAOFM_SEL_MIDREF 2'h2
`define DAOFM_SEL_FLOAT 2'h3

`endif

// ==== hw/daofm_pkg.sv ====
// types of the dual converter output mux
package daofm_pkg;
  typedef enum logic [1:0] {
    SEL_GROUND = 2'b00,
    SEL_SUPPLY = 2'b01,
    SEL_MIDREF = 2'b10,
    SEL_FLOAT = 2'b11
  } daofm_sel_type;
  typedef enum logic {
    PH_A = 1'b0,
    PH_B = 1'b1
  } daofm_phase_type;
endpackage

// ==== hw/daofm_stream_if.sv ====
// valid/ready carrier for a sample pair
`timescale 1ns/10ps
`default_nettype none
`include "daofm_defs.svh"
interface daofm_stream_if;
  logic valid;
  logic ready;
  logic [`DAOFM_PAIR_W-1:0] data;
  modport src(output valid, output data, input ready);
  modport dst(input valid, input data, output ready);
endinterface // daofm_stream_if
`default_nettype wire

// ==== hw/daofm_pair_buffer.sv ====
// two-entry buffer for sample pairs
`timescale 1ns/10ps
`default_nettype none
`include "daofm_defs.svh"
module daofm_pair_buffer (
  // clock and control
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic flush,
  // streams
  daofm_stream_if.dst fill_s,
  daofm_stream_if.src drain_s
);
  logic [`DAOFM_PAIR_W-1:0] mem_reg [`DAOFM_BUF_DEPTH];
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic [1:0] count_reg;
  logic push;
  logic pop;

  assign fill_s.ready = clk_en && (count_reg != 2'h2);
  assign drain_s.valid = (count_reg != 2'h0);
  assign drain_s.data = mem_reg[rd_ptr_reg];
  assign push = fill_s.valid && fill_s.ready;
  assign pop = clk_en && drain_s.valid && drain_s.ready;

  always_ff @(posedge ref_clk) begin
    if (clk_en && push) begin
      mem_reg[wr_ptr_reg] <= fill_s.data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wr_ptr_reg <= 1'h0;
      rd_ptr_reg <= 1'h0;
      count_reg <= 2'h0;
    end else if (clk_en) begin
      if (flush) begin
        wr_ptr_reg <= 1'h0;
        rd_ptr_reg <= 1'h0;
        count_reg <= 2'h0;
      end else begin
        if (push) begin
          wr_ptr_reg <= ~wr_ptr_reg;
        end
        if (pop) begin
          rd_ptr_reg <= ~rd_ptr_reg;
        end
        count_reg <= count_reg + {1'h0, push} - {1'h0, pop};
      end
    end
  end
endmodule // daofm_pair_buffer
`default_nettype wire

// ==== hw/daofm_top.sv ====
// output format, stabilizer select and bus mux of the dual converter
`timescale 1ns/10ps
`default_nettype none
`include "daofm_defs.svh"
module daofm_top (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // converter core samples
  input wire logic [`DAOFM_WORD_W-1:0] sample_a_word,
  input wire logic [`DAOFM_WORD_W-1:0] sample_b_word,
  input wire logic sample_valid,
  output logic sample_ready,
  // control pins
  input wire logic [1:0] format_stabilizer_select,
  input wire logic interleave_select,
  input wire logic output_disable_chan_a,
  input wire logic output_disable_chan_b,
  input wire logic sleep_input,
  input wire logic receiver_ready,
  // mode status
  output logic clock_duty_stabilizer,
  output logic twos_complement_mode,
  // output buses
  output logic [`DAOFM_WORD_W-1:0] first_channel_bus,
  output logic [`DAOFM_WORD_W-1:0] first_channel_bus_oe,
  output logic [`DAOFM_WORD_W-1:0] second_channel_bus,
  output logic [`DAOFM_WORD_W-1:0] second_channel_bus_oe,
  output logic chan_a_valid,
  output logic chan_b_valid
);
  daofm_stream_if fill_s ();
  daofm_stream_if drain_s ();

  daofm_pkg::daofm_sel_type sel;
  daofm_pkg::daofm_phase_type phase_reg;
  logic twos_next;
  logic stab_next;
  logic advance;
  logic pop;
  logic step_b;
  logic [`DAOFM_WORD_W-1:0] held_b_reg;
  logic [`DAOFM_WORD_W-1:0] bus_a_reg;
  logic [`DAOFM_WORD_W-1:0] bus_b_reg;
  logic words_valid_reg;
  logic oe_a_reg;
  logic oe_b_reg;
  logic oe_ind_reg;

  // ******************************************
  // format and stabilizer decode
  // ******************************************
  assign sel = daofm_pkg::daofm_sel_type'(format_stabilizer_select);

  always_comb begin
    case (sel)
      daofm_pkg::SEL_SUPPLY: begin
        twos_next = 1'h0;
        stab_next = 1'h1;
      end
      daofm_pkg::SEL_GROUND: begin
        twos_next = 1'h1;
        stab_next = 1'h1;
      end
      daofm_pkg::SEL_MIDREF: begin
        twos_next = 1'h1;
        stab_next = 1'h0;
      end
      daofm_pkg::SEL_FLOAT: begin
        twos_next = 1'h0;
        stab_next = 1'h0;
      end
      default: begin
        twos_next = 1'h0;
        stab_next = 1'h0;
      end
    endcase
  end

  // changes take effect at the next edge; words may glitch meanwhile
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      twos_complement_mode <= 1'h0;
      clock_duty_stabilizer <= 1'h1;
    end else if (clk_en) begin
      twos_complement_mode <= twos_next;
      clock_duty_stabilizer <= stab_next;
    end
  end

  function automatic logic [`DAOFM_WORD_W-1:0] fmt(input logic [`DAOFM_WORD_W-1:0] w,
                                                   input logic twos);
    fmt = twos ? (w ^ `DAOFM_MID_SCALE) : w;
  endfunction

  // ******************************************
  // sample buffer
  // ******************************************
  // sleep drops samples
  assign fill_s.valid = sample_valid && !sleep_input;
  assign fill_s.data = {sample_a_word, sample_b_word};
  assign sample_ready = fill_s.ready && !sleep_input;

  daofm_pair_buffer u_buf (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .flush(sleep_input),
    .fill_s(fill_s),
    .drain_s(drain_s)
  );

  // ******************************************
  // output sequencing
  // ******************************************
  assign advance = clk_en && receiver_ready && !sleep_input;
  // interleaved: pop only on the A phase; parallel: pop in any phase
  assign drain_s.ready = advance && (!interleave_select || phase_reg == daofm_pkg::PH_A);
  assign pop = drain_s.valid && drain_s.ready;
  assign step_b = advance && interleave_select && phase_reg == daofm_pkg::PH_B;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      phase_reg <= daofm_pkg::PH_A;
    end else if (clk_en) begin
      if (sleep_input || !interleave_select) begin
        phase_reg <= daofm_pkg::PH_A;
      end else if (pop) begin
        phase_reg <= daofm_pkg::PH_B;
      end else if (step_b) begin
        phase_reg <= daofm_pkg::PH_A;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      held_b_reg <= `DAOFM_WORD_RST;
    end else if (clk_en && pop) begin
      held_b_reg <= drain_s.data[`DAOFM_WORD_W-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      bus_a_reg <= `DAOFM_WORD_RST;
      bus_b_reg <= `DAOFM_WORD_RST;
    end else if (clk_en) begin
      if (pop && !interleave_select) begin
        bus_a_reg <= fmt(drain_s.data[`DAOFM_PAIR_W-1:`DAOFM_WORD_W], twos_complement_mode);
        bus_b_reg <= fmt(drain_s.data[`DAOFM_WORD_W-1:0], twos_complement_mode);
      end else if (pop) begin
        bus_a_reg <= fmt(drain_s.data[`DAOFM_PAIR_W-1:`DAOFM_WORD_W], twos_complement_mode);
        bus_b_reg <= 12'h001;
      end else if (step_b) begin
        bus_a_reg <= fmt(held_b_reg, twos_complement_mode);
        bus_b_reg <= 12'h000;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      words_valid_reg <= 1'h0;
    end else if (clk_en) begin
      if (sleep_input) begin
        words_valid_reg <= 1'h0;
      end else if (advance) begin
        words_valid_reg <= pop || step_b;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      oe_a_reg <= 1'h0;
      oe_b_reg <= 1'h0;
      oe_ind_reg <= 1'h0;
    end else if (clk_en) begin
      oe_a_reg <= !output_disable_chan_a && !sleep_input;
      oe_b_reg <= !output_disable_chan_b && !sleep_input && !interleave_select;
      oe_ind_reg <= !output_disable_chan_b && !sleep_input;
    end
  end

  assign first_channel_bus = bus_a_reg;
  assign second_channel_bus = bus_b_reg;
  assign first_channel_bus_oe = {`DAOFM_WORD_W{oe_a_reg}};
  assign second_channel_bus_oe = {{(`DAOFM_WORD_W-1){oe_b_reg}}, oe_ind_reg};
  assign chan_a_valid = words_valid_reg && oe_a_reg;
  assign chan_b_valid = words_valid_reg && oe_b_reg;

  // ******************************************
  // checks
  // ******************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  AST_SEL_SUPPLY: assert property (clk_en && sel == daofm_pkg::SEL_SUPPLY
    |=> !twos_complement_mode && clock_duty_stabilizer) else $error("supply decode wrong");
  AST_SEL_GROUND: assert property (clk_en && sel == daofm_pkg::SEL_GROUND
    |=> twos_complement_mode && clock_duty_stabilizer) else $error("ground decode wrong");
  AST_SEL_MIDREF: assert property (clk_en && sel == daofm_pkg::SEL_MIDREF
    |=> twos_complement_mode && !clock_duty_stabilizer) else $error("midref decode wrong");
  AST_SEL_FLOAT: assert property (clk_en && sel == daofm_pkg::SEL_FLOAT
    |=> !twos_complement_mode && !clock_duty_stabilizer) else $error("float decode wrong");
  AST_PAR_BUSES: assert property (pop && !interleave_select
    |=> second_channel_bus == ($past(drain_s.data[`DAOFM_WORD_W-1:0])
        ^ {$past(twos_complement_mode), 11'h000}))
    else $error("parallel b word wrong");
  AST_ENCODE_A: assert property (pop
    |=> first_channel_bus == ($past(twos_complement_mode)
        ? ($past(drain_s.data[`DAOFM_PAIR_W-1:`DAOFM_WORD_W]) ^ 12'h800)
        : $past(drain_s.data[`DAOFM_PAIR_W-1:`DAOFM_WORD_W]))) else $error("a encoding wrong");
  AST_MUX_IND_A: assert property (pop && interleave_select
    |=> second_channel_bus[0] && words_valid_reg) else $error("indicator not high for a");
  AST_MUX_B_WORD: assert property (step_b
    |=> !second_channel_bus[0]
        && first_channel_bus == ($past(held_b_reg) ^ {$past(twos_complement_mode), 11'h000}))
    else $error("b word or indicator wrong");
  AST_MUX_ALTERNATE: assert property (pop && interleave_select ##1
    receiver_ready && clk_en && interleave_select && !sleep_input
    |-> phase_reg == daofm_pkg::PH_B && !drain_s.ready) else $error("no b phase after a");
  AST_SLEEP_INVALID: assert property (clk_en && sleep_input
    |=> !chan_a_valid && !chan_b_valid && !drain_s.valid) else $error("sleep left data");
  AST_DISABLE_A: assert property (clk_en && output_disable_chan_a
    |=> first_channel_bus_oe == 12'h000 && !chan_a_valid) else $error("a not floated");
  AST_VALID_GATE: assert property (clk_en && (output_disable_chan_b || sleep_input)
    |=> !chan_b_valid) else $error("b valid while disabled");

  COV_PARALLEL: cover property (pop && !interleave_select);
  COV_INTERLEAVE: cover property (pop && interleave_select ##1 step_b);
  COV_STALL_FULL: cover property (!fill_s.ready && clk_en);
  COV_SLEEP: cover property (sleep_input && drain_s.valid);
endmodule // daofm_top
`default_nettype wire

// ==== verification/daofm_receiver.sv ====
// receiving logic model that captures converted words
`timescale 1ns/10ps
`default_nettype none
`include "daofm_defs.svh"
module daofm_receiver (
  // clock and bench control
  input wire logic ref_clk,
  input wire logic hold_off,
  input wire logic interleave_select,
  // device outputs
  input wire logic [`DAOFM_WORD_W-1:0] first_channel_bus,
  input wire logic [`DAOFM_WORD_W-1:0] second_channel_bus,
  input wire logic chan_a_valid,
  input wire logic chan_b_valid,
  // back-pressure and captured words
  output var logic receiver_ready,
  output logic got_a,
  output logic got_b,
  output logic [`DAOFM_WORD_W-1:0] word_a,
  output logic [`DAOFM_WORD_W-1:0] word_b
);
  // ************
  // capture side
  // ************
  initial receiver_ready = 1'b0;
  // random stalls between edges
  always @(negedge ref_clk) begin
    receiver_ready <= !hold_off && ($urandom_range(3) != 0);
  end
  assign got_a = receiver_ready & chan_a_valid & (!interleave_select | second_channel_bus[0]);
  assign got_b = receiver_ready & (interleave_select ? chan_a_valid & !second_channel_bus[0]
                                                      : chan_b_valid);
  assign word_a = first_channel_bus;
  assign word_b = interleave_select ? first_channel_bus : second_channel_bus;
endmodule // daofm_receiver
`default_nettype wire

// ==== verification/dual_adc_output_format_mux_bench.sv ====
// self-checking bench of the dual converter output mux
`timescale 1ns/10ps
`default_nettype none
`include "daofm_defs.svh"
module dual_adc_output_format_mux_bench;
  logic ref_clk, sys_rst, sample_valid, sample_ready, interleave_select;
  logic output_disable_chan_a, output_disable_chan_b, sleep_input, receiver_ready;
  logic clock_duty_stabilizer, twos_complement_mode, chan_a_valid, chan_b_valid;
  logic hold_off, got_a, got_b, cur_twos, clk_en;
  logic [1:0] format_stabilizer_select;
  logic [11:0] sample_a_word, sample_b_word, word_a, word_b;
  logic [11:0] first_channel_bus, first_channel_bus_oe, second_channel_bus, second_channel_bus_oe;
  logic [11:0] exp_a[$], exp_b[$];
  int n_fail = 0;
  int checked = 0;
  daofm_top i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .sample_a_word(sample_a_word), .sample_b_word(sample_b_word),
    .sample_valid(sample_valid), .sample_ready(sample_ready),
    .format_stabilizer_select(format_stabilizer_select), .interleave_select(interleave_select),
    .output_disable_chan_a(output_disable_chan_a), .output_disable_chan_b(output_disable_chan_b),
    .sleep_input(sleep_input), .receiver_ready(receiver_ready),
    .clock_duty_stabilizer(clock_duty_stabilizer), .twos_complement_mode(twos_complement_mode),
    .first_channel_bus(first_channel_bus), .first_channel_bus_oe(first_channel_bus_oe),
    .second_channel_bus(second_channel_bus), .second_channel_bus_oe(second_channel_bus_oe),
    .chan_a_valid(chan_a_valid), .chan_b_valid(chan_b_valid));
  daofm_receiver i_rx (.ref_clk(ref_clk), .hold_off(hold_off),
    .interleave_select(interleave_select), .first_channel_bus(first_channel_bus),
    .second_channel_bus(second_channel_bus), .chan_a_valid(chan_a_valid),
    .chan_b_valid(chan_b_valid), .receiver_ready(receiver_ready), .got_a(got_a),
    .got_b(got_b), .word_a(word_a), .word_b(word_b));
  // *********************
  // checks and conclusion
  // *********************
  task automatic check_word(input string what, input logic [11:0] exp, input logic [11:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_bit(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("checked %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // two's complement flips the top bit
  function automatic logic [11:0] fmt(input logic [11:0] raw);
    return raw ^ {cur_twos, 11'h000};
  endfunction
  always @(posedge ref_clk) begin
    if (!sys_rst && got_a) begin
      check_bit("a pending", 1'b1, exp_a.size() != 0);
      if (exp_a.size() != 0) check_word("word a", fmt(exp_a.pop_front()), word_a);
    end
    if (!sys_rst && got_b) begin
      check_bit("b pending", 1'b1, exp_b.size() != 0);
      if (exp_b.size() != 0) check_word("word b", fmt(exp_b.pop_front()), word_b);
    end
    if (!sys_rst && interleave_select && (got_a || got_b)) begin
      check_word("upper second bus", 12'h000, second_channel_bus & 12'hffe);
    end
  end
  // ********
  // stimulus
  // ********
  task automatic send(input logic [11:0] a, input logic [11:0] b);
    sample_a_word = a;
    sample_b_word = b;
    sample_valid = 1'b1;
    // ready only moves at the rising edge, so look before it
    for (int k = 0; k < 200 && sample_ready !== 1'b1; k++) @(negedge ref_clk);
    @(posedge ref_clk);
    exp_a.push_back(a);
    exp_b.push_back(b);
    @(negedge ref_clk);
  endtask
  task automatic drain();
    sample_valid = 1'b0;
    for (int k = 0; k < 300 && (exp_a.size() + exp_b.size()) != 0; k++) @(negedge ref_clk);
    check_bit("drained", 1'b1, (exp_a.size() + exp_b.size()) == 0);
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    #(25 * 30000);
    n_fail++;
    conclude();
  end
  initial begin
    void'($urandom(45541));
    {sys_rst, hold_off} = 2'b11;
    clk_en = 1'b1;
    {sample_valid, interleave_select, output_disable_chan_a} = 3'b000;
    {output_disable_chan_b, sleep_input, cur_twos} = 3'b000;
    format_stabilizer_select = 2'h1;
    sample_a_word = 12'h000;
    sample_b_word = 12'h000;
    repeat (10) @(posedge ref_clk);
    @(negedge ref_clk);
    sys_rst = 1'b0;
    hold_off = 1'b0;
    for (int m = 0; m < 8; m++) begin
      format_stabilizer_select = m[1:0];
      interleave_select = m[2];
      cur_twos = (m[1:0] == 2'h0) || (m[1:0] == 2'h2);
      repeat (2) @(negedge ref_clk);
      check_bit("stabilizer", m[1:0] < 2'h2, clock_duty_stabilizer);
      check_bit("twos mode", cur_twos, twos_complement_mode);
      send(12'h800, 12'hfff);
      send(12'h000, 12'h7ff);
      for (int i = 0; i < 12; i++) send(12'($urandom), 12'($urandom));
      drain();
    end
    // output disables and floating
    for (int d = 0; d < 8; d++) begin
      {interleave_select, output_disable_chan_b, output_disable_chan_a} = d[2:0];
      repeat (2) @(negedge ref_clk);
      check_word("first oe", {12{!d[0]}}, first_channel_bus_oe);
      check_word("second oe", {{11{!d[1] & !d[2]}}, !d[1]}, second_channel_bus_oe);
    end
    {interleave_select, output_disable_chan_b, output_disable_chan_a} = 3'b000;
    // frozen enable: sleep ignored, held word kept
    hold_off = 1'b1;
    send(12'h321, 12'h654);
    clk_en = 1'b0;
    sleep_input = 1'b1;
    repeat (3) @(negedge ref_clk);
    sleep_input = 1'b0;
    @(negedge ref_clk);
    check_bit("ready frozen", 1'b0, sample_ready);
    clk_en = 1'b1;
    hold_off = 1'b0;
    drain();
    // sleep with words held: they are lost
    hold_off = 1'b1;
    send(12'h123, 12'h456);
    send(12'h789, 12'habc);
    sample_valid = 1'b0;
    repeat (3) @(negedge ref_clk);
    sleep_input = 1'b1;
    repeat (2) @(negedge ref_clk);
    check_word("oe in sleep", 12'h000, first_channel_bus_oe | second_channel_bus_oe);
    check_bit("valid in sleep", 1'b0, chan_a_valid | chan_b_valid);
    exp_a.delete();
    exp_b.delete();
    sleep_input = 1'b0;
    hold_off = 1'b0;
    repeat (8) @(negedge ref_clk);
    send(12'h5a5, 12'ha5a);
    drain();
    conclude();
  end
endmodule // dual_adc_output_format_mux_bench
`default_nettype wire
